// ==== rtl/ref_validation_irq_clear_ctrl.sv ====
/*
  Write-triggered control bank for two reference inputs: interrupt monitor with
  clearing, phase offset step commands, forced validation timeout, monitor
  override and monitor bypass, reached over APB (one wait state per transfer).
  Assumes the phase accumulator and validation timers sit outside and act on
  the one-cycle pulses; reference fault inputs arrive asynchronously.
*/
// Added by the designer: the APB register port.
//
// Contract
// [R1] Writing 1 to bits 6, 5, 4 of the clear register clears the second input's validated, fault-cleared and fault interrupt bits.
// [R2] Writing 1 to bits 2, 1, 0 of the clear register clears the first input's validated, fault-cleared and fault interrupt bits.
// [R3] Writing 1 to phase control bit 2 zeroes the incremental phase offset and the bit clears itself.
// [R4] Writing 1 to phase control bit 1 subtracts one phase step once and the bit clears itself.
// [R5] Writing 1 to phase control bit 0 adds one phase step once and the bit clears itself.
// [R6] Writing 1 to forced timeout bit 1 acts as expiry of the second input's validation timer, self clearing.
// [R7] Writing 1 to forced timeout bit 0 acts as expiry of the first input's validation timer, self clearing.
// [R8] While override bit 1 is set the second input's fault is overridden and the input is invalid.
// [R9] While override bit 0 is set the first input is invalid regardless of its monitor.
// [R10] Both override bits reset to zero so no input is forced invalid after reset.
// [R11] Setting bypass bit 1 ignores the second input's monitor and starts its validation timer; resets to zero.
// [R12] Setting bypass bit 0 ignores the first input's monitor and starts its validation timer; resets to zero.
// [R13] Bypass first and then forced timeout makes that input reported valid.
// [R14] Software does not set bypass and forced timeout of one input in the same write.
// [R15] Each clearing bit written as 1 resets the matching latched interrupt bit and withdraws its request; an event in the clearing cycle keeps it set.
// [R16] Clearing bits clear themselves, no write of 0 needed.
// [R17] Command bits give one one-cycle pulse per write of 1 and read as 0; reserved bits read 0 and ignore writes.
`timescale 1ns/1ps

module ref_validation_irq_clear_ctrl (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// APB slave
	input  wire logic [15:0]  paddr,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [31:0]  pwdata,
	output logic      [31:0]  prdata,
	output logic              pready,
	output logic              pslverr,
	// Reference monitor fault levels, asynchronous
	input  wire logic [1:0]   ref_fault_in,
	// Validation timer expiry pulses, same clock
	input  wire logic [1:0]   timer_expired,
	// Phase offset commands to the accumulator
	output logic              phase_zero_pulse,
	output logic              phase_dec_pulse,
	output logic              phase_inc_pulse,
	// Validation control per reference
	output logic      [1:0]   force_timeout_pulse,
	output logic      [1:0]   timer_start_pulse,
	output logic      [1:0]   ref_forced_invalid,
	output logic      [1:0]   monitor_bypass,
	output logic      [1:0]   ref_fault_eff,
	output logic      [1:0]   ref_valid,
	// Interrupt
	output logic              irq
);

	logic [13:0]  idx;
	logic         access_done;
	logic         wr_en;
	logic         rd_miss;
	logic [31:0]  rd_data;
	logic [1:0]   fault_sync;
	logic [2:0]   phase_cmd_q;
	logic [1:0]   force_q;
	logic [1:0]   start_q;
	logic [1:0]   override_q;
	logic [1:0]   bypass_q;
	logic [1:0]   fault_eff_q;
	logic [1:0]   fault_prev_q;
	logic [1:0]   valid_q;
	logic [1:0]   valid_prev_q;
	logic [7:0]   irq_evt;
	logic [7:0]   irq_clr;
	logic [7:0]   status_d;
	logic [7:0]   status_q;
	logic [7:0]   mask_q;
	logic         irq_q;
	logic         pready_q;
	logic         pslverr_q;
	logic [31:0]  prdata_q;

	// Word index; low address bits ignored
	assign idx         = paddr[15:2];
	assign access_done = psel & penable & pready_q;
	assign wr_en       = access_done & pwrite;

	// Fault levels come from another domain
	sync_two_flop #(
		.WIDTH    (ref_ctrl_pkg::NUM_REFS)
	) u_fault_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (ref_fault_in),
		.sync_out (fault_sync)
	);

	// Read mux; command registers read as zero
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_miss = 1'b0;
		case (idx)
			ref_ctrl_pkg::IDX_REF_IRQ_CLEAR,
			ref_ctrl_pkg::IDX_RESERVED_CLEAR,
			ref_ctrl_pkg::IDX_PHASE_STEP_CTRL,
			ref_ctrl_pkg::IDX_FORCED_TIMEOUT:   rd_data = 32'h0000_0000; // see [R17]
			ref_ctrl_pkg::IDX_INVALID_OVERRIDE: rd_data = {30'h0, override_q};
			ref_ctrl_pkg::IDX_BYPASS_CTRL:      rd_data = {30'h0, bypass_q};
			ref_ctrl_pkg::IDX_IRQ_STATUS:       rd_data = {24'h0, status_q};
			ref_ctrl_pkg::IDX_IRQ_MASK:         rd_data = {24'h0, mask_q};
			ref_ctrl_pkg::IDX_REF_STATE:
			begin
				rd_data[ref_ctrl_pkg::STATE_VALID_LSB +: 2] = valid_q;
				rd_data[ref_ctrl_pkg::STATE_FAULT_LSB +: 2] = fault_eff_q;
			end
			default:                            rd_miss = 1'b1;
		endcase
	end

	// One wait state: answer registered so outputs come from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= ref_ctrl_pkg::RDATA_RESET;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_q  <= 1'b1;
			pslverr_q <= rd_miss;
			prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
		end
		else
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end
	end

	// Phase commands: one pulse per write of 1, gone the next cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase_cmd_q <= 3'h0;
		else if (wr_en && !rd_miss && idx == ref_ctrl_pkg::IDX_PHASE_STEP_CTRL)
			phase_cmd_q <= pwdata[2:0]; // see [R3] see [R4] see [R5] see [R17]
		else
			phase_cmd_q <= 3'h0;
	end

	// Forced timeout pulses, self clearing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			force_q <= 2'h0;
		else if (wr_en && idx == ref_ctrl_pkg::IDX_FORCED_TIMEOUT)
			force_q <= pwdata[1:0]; // see [R6] see [R7]
		else
			force_q <= 2'h0;
	end

	// Override levels; reserved bits dropped on write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			override_q <= ref_ctrl_pkg::OVERRIDE_RESET; // see [R10]
		else if (wr_en && idx == ref_ctrl_pkg::IDX_INVALID_OVERRIDE)
			override_q <= pwdata[1:0];
	end

	// Bypass levels; a 0-to-1 write starts the validation timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bypass_q <= ref_ctrl_pkg::BYPASS_RESET;
			start_q  <= 2'h0;
		end
		else if (wr_en && idx == ref_ctrl_pkg::IDX_BYPASS_CTRL)
		begin
			bypass_q <= pwdata[1:0];
			start_q  <= pwdata[1:0] & ~bypass_q; // see [R11] see [R12]
		end
		else
			start_q  <= 2'h0;
	end

	// Per-reference validation state and interrupt events
	for (genvar i = 0; i < ref_ctrl_pkg::NUM_REFS; i++)
	begin : g_ref
		localparam int BASE = i * ref_ctrl_pkg::REF_STRIDE;

		// Override wins over the monitor; bypass hides the monitor
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				fault_eff_q[i]  <= 1'b0;
				fault_prev_q[i] <= 1'b0;
				valid_prev_q[i] <= 1'b0;
			end
			else
			begin
				fault_eff_q[i]  <= override_q[i] | (fault_sync[i] & ~bypass_q[i]); // see [R8] see [R9]
				fault_prev_q[i] <= fault_eff_q[i];
				valid_prev_q[i] <= valid_q[i];
			end
		end

		// Fault clears validity; timer expiry or forced timeout sets it
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				valid_q[i] <= 1'b0;
			else if (fault_eff_q[i])
				valid_q[i] <= 1'b0; // see [R8] see [R9]
			else if (force_q[i] || timer_expired[i])
				valid_q[i] <= 1'b1; // see [R13]
		end

		// Edges of fault and validity raise the monitor events
		assign irq_evt[BASE + ref_ctrl_pkg::BIT_FAULT]         = fault_eff_q[i] & ~fault_prev_q[i];
		assign irq_evt[BASE + ref_ctrl_pkg::BIT_FAULT_CLEARED] = ~fault_eff_q[i] & fault_prev_q[i];
		assign irq_evt[BASE + ref_ctrl_pkg::BIT_VALIDATED]     = valid_q[i] & ~valid_prev_q[i];
		assign irq_evt[BASE + 3]                               = 1'b0;

		// Reaching valid takes one cycle after the pulse when nothing faults
		sequence s_forced_clean;
			force_q[i] && !fault_eff_q[i];
		endsequence

		sequence s_override_held;
			override_q[i] ##1 fault_eff_q[i];
		endsequence

		a_force_makes_valid: // see [R13]
		assert property (@(posedge pclk) disable iff (!presetn)
			s_forced_clean |=> valid_q[i])
		else $error("forced timeout did not validate reference");

		a_override_invalid: // see [R8] see [R9]
		assert property (@(posedge pclk) disable iff (!presetn)
			override_q[i] ##1 override_q[i] |-> fault_eff_q[i] ##1 !valid_q[i])
		else $error("override did not invalidate reference");

		a_override_fault_seq: // see [R8]
		assert property (@(posedge pclk) disable iff (!presetn)
			$rose(override_q[i]) |-> s_override_held)
		else $error("override did not raise effective fault");

		a_bypass_starts_timer: // see [R11] see [R12]
		assert property (@(posedge pclk) disable iff (!presetn)
			wr_en && idx == ref_ctrl_pkg::IDX_BYPASS_CTRL && pwdata[i] && !bypass_q[i]
			|=> start_q[i] && bypass_q[i] ##1 !start_q[i])
		else $error("bypass write did not start validation timer");

		a_force_pulse_once: // see [R6] see [R7]
		assert property (@(posedge pclk) disable iff (!presetn)
			wr_en && idx == ref_ctrl_pkg::IDX_FORCED_TIMEOUT && pwdata[i]
			|=> force_q[i] ##1 !force_q[i])
		else $error("forced timeout pulse not exactly one cycle");
	end

	// Clear strobes from the clear register or write-one to status
	assign irq_clr = (wr_en && (idx == ref_ctrl_pkg::IDX_REF_IRQ_CLEAR ||
	                            idx == ref_ctrl_pkg::IDX_IRQ_STATUS))
	               ? (pwdata[7:0] & ref_ctrl_pkg::IRQ_USED_BITS) : 8'h00;

	// Set beats clear so an event in the clearing cycle survives
	assign status_d = irq_evt | (status_q & ~irq_clr); // see [R1] see [R2] see [R15] see [R16]

	// Sticky monitor bits and mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			status_q <= ref_ctrl_pkg::IRQ_STATUS_RESET;
			mask_q   <= ref_ctrl_pkg::IRQ_MASK_RESET;
		end
		else
		begin
			status_q <= status_d;
			if (wr_en && idx == ref_ctrl_pkg::IDX_IRQ_MASK)
				mask_q <= pwdata[7:0] & ref_ctrl_pkg::IRQ_USED_BITS;
		end
	end

	// Registered level interrupt, one cycle behind status
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_q <= 1'b0;
		else
			irq_q <= |(status_q & mask_q); // see [R15]
	end

	// Outputs straight from flops
	assign prdata              = prdata_q;
	assign pready              = pready_q;
	assign pslverr             = pslverr_q;
	assign phase_zero_pulse    = phase_cmd_q[ref_ctrl_pkg::BIT_PHASE_ZERO];
	assign phase_dec_pulse     = phase_cmd_q[ref_ctrl_pkg::BIT_PHASE_DEC];
	assign phase_inc_pulse     = phase_cmd_q[ref_ctrl_pkg::BIT_PHASE_INC];
	assign force_timeout_pulse = force_q;
	assign timer_start_pulse   = start_q;
	assign ref_forced_invalid  = override_q;
	assign monitor_bypass      = bypass_q;
	assign ref_fault_eff       = fault_eff_q;
	assign ref_valid           = valid_q;
	assign irq                 = irq_q;

	a_clear_second_ref: // see [R1]
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && idx == ref_ctrl_pkg::IDX_REF_IRQ_CLEAR && pwdata[6] && !irq_evt[6]
		|=> !status_q[6])
	else $error("second reference validated bit not cleared");

	a_clear_first_ref: // see [R2]
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && idx == ref_ctrl_pkg::IDX_REF_IRQ_CLEAR && pwdata[0] && !irq_evt[0]
		|=> !status_q[0])
	else $error("first reference fault bit not cleared");

	a_phase_zero_pulse: // see [R3]
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && idx == ref_ctrl_pkg::IDX_PHASE_STEP_CTRL && pwdata[2]
		|=> phase_zero_pulse ##1 !phase_zero_pulse)
	else $error("phase zero pulse wrong");

	a_phase_dec_pulse: // see [R4]
	assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && idx == ref_ctrl_pkg::IDX_PHASE_STEP_CTRL && pwdata[1]
		|=> phase_dec_pulse ##1 !phase_dec_pulse)
	else $error("phase decrement pulse wrong");

	a_phase_inc_pulse: // see [R5]
	assert property (@(posedge pclk) disable iff (!presetn)
		$rose(phase_inc_pulse) |->
		$past(wr_en && idx == ref_ctrl_pkg::IDX_PHASE_STEP_CTRL && pwdata[0]) ##1 !phase_inc_pulse)
	else $error("phase increment pulse without write");

	a_override_reset: // see [R10]
	assert property (@(posedge pclk)
		!presetn |-> ref_forced_invalid == 2'h0 && monitor_bypass == 2'h0)
	else $error("override or bypass not zero in reset");

	a_irq_follows_status: // see [R15]
	assert property (@(posedge pclk) disable iff (!presetn)
		(|(status_q & mask_q)) ##1 (|(status_q & mask_q)) |-> irq)
	else $error("interrupt not raised for unmasked status");

	a_cmd_reads_zero: // see [R17]
	assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pready_q && !pwrite &&
		(idx == ref_ctrl_pkg::IDX_REF_IRQ_CLEAR || idx == ref_ctrl_pkg::IDX_FORCED_TIMEOUT)
		|=> pready && prdata == 32'h0000_0000)
	else $error("command register read not zero");

endmodule : ref_validation_irq_clear_ctrl

// ==== common/ref_ctrl_pkg.sv ====
/*
  Constants for the reference validation and interrupt clearing register bank:
  register indices, field positions, reset values and synchroniser depth.
  Assumes a 32-bit APB slave where each register index maps to byte address 4*index.
*/
package ref_ctrl_pkg;

	// Register indices (byte address = 4 * index)
	localparam int             IDX_W                 = 14;
	localparam logic [13:0]    IDX_REF_IRQ_CLEAR     = 14'h0A08;
	localparam logic [13:0]    IDX_RESERVED_CLEAR    = 14'h0A09;
	localparam logic [13:0]    IDX_PHASE_STEP_CTRL   = 14'h0A0A;
	localparam logic [13:0]    IDX_FORCED_TIMEOUT    = 14'h0A0B;
	localparam logic [13:0]    IDX_INVALID_OVERRIDE  = 14'h0A0C;
	localparam logic [13:0]    IDX_BYPASS_CTRL       = 14'h0A0D;
	localparam logic [13:0]    IDX_IRQ_STATUS        = 14'h0D02;
	localparam logic [13:0]    IDX_IRQ_MASK          = 14'h0E00;
	localparam logic [13:0]    IDX_REF_STATE         = 14'h0E01;

	// Reference count and per-reference field layout of the interrupt bytes
	localparam int             NUM_REFS              = 2;
	localparam int             REF_STRIDE            = 4;
	localparam int             BIT_FAULT             = 0;
	localparam int             BIT_FAULT_CLEARED     = 1;
	localparam int             BIT_VALIDATED         = 2;
	localparam logic [7:0]     IRQ_USED_BITS         = 8'h77;

	// Phase offset command bits
	localparam int             BIT_PHASE_ZERO        = 2;
	localparam int             BIT_PHASE_DEC         = 1;
	localparam int             BIT_PHASE_INC         = 0;

	// Reference state readback: valid in [1:0], effective fault in [5:4]
	localparam int             STATE_VALID_LSB       = 0;
	localparam int             STATE_FAULT_LSB       = 4;

	// Values after reset
	localparam logic [1:0]     OVERRIDE_RESET        = 2'h0;
	localparam logic [1:0]     BYPASS_RESET          = 2'h0;
	localparam logic [7:0]     IRQ_STATUS_RESET      = 8'h00;
	localparam logic [7:0]     IRQ_MASK_RESET        = 8'h00;
	localparam logic [31:0]    RDATA_RESET           = 32'h0000_0000;

	// Synchroniser depth for pin inputs
	localparam int             SYNC_STAGES           = 2;

endpackage : ref_ctrl_pkg

// ==== rtl/sync_two_flop.sv ====
/*
  Two-flop level synchroniser, one chain per bit.
  Assumes inputs are quasi-static levels; pulses shorter than two clocks may be lost.
*/
`timescale 1ns/1ps

module sync_two_flop #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// Data
	input  wire logic [WIDTH-1:0]   async_in,
	output logic      [WIDTH-1:0]   sync_out
);

	logic [WIDTH-1:0] meta_q;

	// First stage feeds only the second stage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule : sync_two_flop

// ==== tb/tb.sv ====
/*
  Self-checking bench for the reference validation and interrupt clearing bank.
  Assumes the bank gives one-cycle pulses; APB transfers may take any number of wait states.
*/
`timescale 1ns/1ps

module tb;

	logic          pclk;
	logic          presetn;
	logic [15:0]   paddr;
	logic          psel;
	logic          penable;
	logic          pwrite;
	logic [31:0]   pwdata;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	logic [1:0]    ref_fault_in;
	logic [1:0]    timer_expired;
	logic          phase_zero_pulse;
	logic          phase_dec_pulse;
	logic          phase_inc_pulse;
	logic [1:0]    force_timeout_pulse;
	logic [1:0]    timer_start_pulse;
	logic [1:0]    ref_forced_invalid;
	logic [1:0]    monitor_bypass;
	logic [1:0]    ref_fault_eff;
	logic [1:0]    ref_valid;
	logic          irq;
	int            n_fail;
	int            checks_done;
	int            pc [3];
	int            ft_cnt [2];
	int            ts_cnt [2];
	logic [31:0]   rd;
	logic          err;

	ref_validation_irq_clear_ctrl ref_validation_irq_clear_ctrl_inst (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_fault_in(ref_fault_in),
		.timer_expired(timer_expired), .phase_zero_pulse(phase_zero_pulse),
		.phase_dec_pulse(phase_dec_pulse), .phase_inc_pulse(phase_inc_pulse),
		.force_timeout_pulse(force_timeout_pulse), .timer_start_pulse(timer_start_pulse),
		.ref_forced_invalid(ref_forced_invalid), .monitor_bypass(monitor_bypass),
		.ref_fault_eff(ref_fault_eff), .ref_valid(ref_valid), .irq(irq)
	);

	// Free-running 100 MHz clock
	always #5 pclk = ~pclk;

	// Count pulses so a doubled or missing pulse shows up as a wrong count
	always @(posedge pclk)
	begin
		pc[0]     <= pc[0] + int'(phase_inc_pulse);
		pc[1]     <= pc[1] + int'(phase_dec_pulse);
		pc[2]     <= pc[2] + int'(phase_zero_pulse);
		ft_cnt[0] <= ft_cnt[0] + int'(force_timeout_pulse[0]);
		ft_cnt[1] <= ft_cnt[1] + int'(force_timeout_pulse[1]);
		ts_cnt[0] <= ts_cnt[0] + int'(timer_start_pulse[0]);
		ts_cnt[1] <= ts_cnt[1] + int'(timer_start_pulse[1]);
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	end
	endtask : check

	task automatic close_out;
	begin
		$display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask : close_out

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic [13:0] idx, input logic wr, input logic [31:0] wd);
		int n;
	begin
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// No cycle count assumed; only the watchdog ends a stuck wait
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		check({31'h0, pready}, 32'h1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	end
	endtask : apb

	task automatic rdchk(input logic [13:0] idx, input logic [31:0] exp);
	begin
		apb(idx, 1'b0, 32'h0);
		check(rd, exp);
	end
	endtask : rdchk

	task automatic idle(input int n);
	begin
		repeat (n) @(posedge pclk);
	end
	endtask : idle

	// Watchdog: the sequence needs a few hundred cycles at most
	initial
	begin
		#200us;
		n_fail++;
		close_out();
	end

	// Main sequence
	initial
	begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0;
		pwdata = 32'h0;
		ref_fault_in = 2'h0;
		timer_expired = 2'h0;
		n_fail = 0;
		checks_done = 0;
		pc = '{0, 0, 0};
		ft_cnt = '{0, 0};
		ts_cnt = '{0, 0};
		idle(12);
		presetn <= 1'b1;
		check({30'h0, ref_forced_invalid}, 32'h0);
		rdchk(ref_ctrl_pkg::IDX_INVALID_OVERRIDE, 32'h0);
		rdchk(ref_ctrl_pkg::IDX_BYPASS_CTRL, 32'h0);
		apb(ref_ctrl_pkg::IDX_RESERVED_CLEAR, 1'b1, 32'hFF);
		rdchk(ref_ctrl_pkg::IDX_RESERVED_CLEAR, 32'h0);
		apb(14'h0100, 1'b0, 32'h0);
		check({31'h0, err}, 32'h1);
		// Each phase command alone, exactly one pulse each
		for (int i = 0; i < 3; i++)
		begin
			apb(ref_ctrl_pkg::IDX_PHASE_STEP_CTRL, 1'b1, 32'h1 << i);
			idle(3);
			for (int j = 0; j < 3; j++)
				check(32'(pc[j]), (j <= i) ? 32'h1 : 32'h0);
			rdchk(ref_ctrl_pkg::IDX_PHASE_STEP_CTRL, 32'h0);
		end
		// Bypass then forced timeout, never in one write
		apb(ref_ctrl_pkg::IDX_IRQ_MASK, 1'b1, 32'h77);
		for (int r = 0; r < 2; r++)
		begin
			apb(ref_ctrl_pkg::IDX_BYPASS_CTRL, 1'b1, (32'h1 << (r + 1)) - 32'h1);
			idle(3);
			check(32'(ts_cnt[r]), 32'h1);
			check({31'h0, monitor_bypass[r]}, 32'h1);
			apb(ref_ctrl_pkg::IDX_FORCED_TIMEOUT, 1'b1, 32'h1 << r);
			idle(3);
			check(32'(ft_cnt[r]), 32'h1);
			check({31'h0, ref_valid[r]}, 32'h1);
		end
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h44);
		check({31'h0, irq}, 32'h1);
		apb(ref_ctrl_pkg::IDX_REF_IRQ_CLEAR, 1'b1, 32'h04);
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h40);
		check({31'h0, irq}, 32'h1);
		apb(ref_ctrl_pkg::IDX_REF_IRQ_CLEAR, 1'b1, 32'h40);
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h0);
		check({31'h0, irq}, 32'h0);
		rdchk(ref_ctrl_pkg::IDX_REF_IRQ_CLEAR, 32'h0);
		// Faults ignored while bypassed, seen once bypass is dropped
		ref_fault_in <= 2'h3;
		idle(8);
		check({30'h0, ref_fault_eff}, 32'h0);
		apb(ref_ctrl_pkg::IDX_BYPASS_CTRL, 1'b1, 32'h0);
		idle(8);
		check({30'h0, ref_fault_eff}, 32'h3);
		check({30'h0, ref_valid}, 32'h0);
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h11);
		apb(ref_ctrl_pkg::IDX_IRQ_MASK, 1'b1, 32'h0);
		idle(2);
		check({31'h0, irq}, 32'h0);
		ref_fault_in <= 2'h0;
		idle(8);
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h33);
		apb(ref_ctrl_pkg::IDX_REF_IRQ_CLEAR, 1'b1, 32'h33);
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h0);
		// Valid inputs pushed invalid by the override bits
		apb(ref_ctrl_pkg::IDX_FORCED_TIMEOUT, 1'b1, 32'h3);
		idle(3);
		check({30'h0, ref_valid}, 32'h3);
		apb(ref_ctrl_pkg::IDX_INVALID_OVERRIDE, 1'b1, 32'h3);
		idle(3);
		rdchk(ref_ctrl_pkg::IDX_INVALID_OVERRIDE, 32'h3);
		check({30'h0, ref_forced_invalid}, 32'h3);
		check({30'h0, ref_fault_eff}, 32'h3);
		check({30'h0, ref_valid}, 32'h0);
		rdchk(ref_ctrl_pkg::IDX_REF_STATE, 32'h30);
		// Status also cleared by writing ones to it
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h55);
		apb(ref_ctrl_pkg::IDX_IRQ_STATUS, 1'b1, 32'h55);
		rdchk(ref_ctrl_pkg::IDX_IRQ_STATUS, 32'h0);
		// Override released; a real timer expiry validates the first input only
		apb(ref_ctrl_pkg::IDX_INVALID_OVERRIDE, 1'b1, 32'h0);
		idle(4);
		check({30'h0, ref_forced_invalid}, 32'h0);
		timer_expired <= 2'h1;
		idle(1);
		timer_expired <= 2'h0;
		idle(2);
		check({30'h0, ref_valid}, 32'h1);
		close_out();
	end

endmodule : tb
